// ---- shared/shwc_pkg.sv ----
// Constants, types and layouts shared by the standby, halt and wake controller.
// Assumes an 8-bit CPU memory port and a system clock that keeps running.
//
// Contract
// - Selected stabilization wait applies after stop only with crystal or ceramic clock.
// - High-speed on-chip or external clock source gets no wait after stop.
// - Select code 00,01,10,11 gives 2^10, 2^12, 2^15, 2^17 oscillator cycles.
// - Wait select register is one byte; bits 7..2 read zero, 1..0 hold code.
// - Wait counting starts only after oscillation has started, for any release.
// - Halt instruction gates the CPU clock; the system oscillator keeps running.
// - An unmasked pending request at standby entry makes standby end at once.
// - Port output latches keep their values during halt.
// - Timers, converter, serial link, voltage detector, external interrupts run in halt.
// - Timer unit one runs in halt unless on a stopped, stoppable low-speed clock.
// - Watchdog in halt runs only on low-speed clock that cannot be stopped.
// - Unmasked request releases halt; enable set vectors, clear resumes next instruction.
// - Release waits 9 or 10 clocks before vectoring, 1 or 2 before resuming.
// - Reset releases halt and restarts from the reset vector.
// - After reset, hold for 8 low-speed plus 96 high-speed oscillator periods.
package shwc_pkg;

   // Register map and layout
   localparam logic [15:0] WAIT_SEL_ADDR  = 16'hfff4;
   localparam int          WAIT_SEL_LSB   = 0;
   localparam logic [1:0]  WAIT_SEL_RST   = 2'h3;
   localparam logic [7:0]  RDATA_IDLE     = 8'h00;

   // Select codes
   localparam logic [1:0]  WAIT_CODE_10   = 2'h0;
   localparam logic [1:0]  WAIT_CODE_12   = 2'h1;
   localparam logic [1:0]  WAIT_CODE_15   = 2'h2;
   localparam logic [1:0]  WAIT_CODE_17   = 2'h3;

   // Cycle counts
   localparam int          CLK_HZ         = 20_000_000;
   localparam int          WAIT_CYC_10    = 1024;
   localparam int          WAIT_CYC_12    = 4096;
   localparam int          WAIT_CYC_15    = 32768;
   localparam int          WAIT_CYC_17    = 131072;
   localparam int          CNT_W          = 18;
   localparam int          OPT_LS_PERIODS = 8;
   localparam int          OPT_HS_PERIODS = 96;
   localparam int          VEC_WAIT_CLK   = 9;
   localparam int          NEXT_WAIT_CLK  = 1;

   // Controller states, one-hot
   typedef enum logic [6:0] {
      ST_OPT    = 7'h01,
      ST_RUN    = 7'h02,
      ST_HALT   = 7'h04,
      ST_STOP   = 7'h08,
      ST_OSC    = 7'h10,
      ST_STAB   = 7'h20,
      ST_RESUME = 7'h40
   } shwc_state_t;

   // CPU memory access to the wait select register
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } shwc_mem_req_t;

   // Clock generator and option settings
   typedef struct packed {
      logic src_xtal;      // Crystal or ceramic is the system clock
      logic ls_stoppable;  // Low-speed oscillator may be stopped by software
      logic ls_stopped;    // Low-speed oscillator stopped by software
      logic tmh1_on_ls;    // Timer unit one counts low-speed clock / 2^7
      logic wdt_on_ls;     // Watchdog counts low-speed clock
   } shwc_clk_cfg_t;

   // Peripheral run enables
   typedef struct packed {
      logic tmr16;
      logic tmr8;
      logic tmh1;
      logic wdt;
      logic adc;
      logic uart;
      logic lvd;
      logic extint;
   } shwc_periph_run_t;

endpackage

// ---- design/shwc_sync3.sv ----
// Three-stage synchroniser with agreement filter for one asynchronous level.
// Assumes the level is slow against CLK; output changes once stages 2 and 3 agree.
`timescale 1ns/10ps
`default_nettype none
module shwc_sync3 (
   // Clock and reset
   input  wire logic CLK,
   input  wire logic RST,
   // Level
   input  wire logic d,
   output var  logic q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Stage 1 feeds only stage 2, so metastability stays contained
   always_ff @(posedge CLK) begin
      if (RST) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a change only when the last two stages agree
   always_ff @(posedge CLK) begin
      if (RST) begin
         q <= 1'b0;
      end else if (s2_q == s3_q) begin
         q <= s3_q;
      end
   end
endmodule // shwc_sync3
`default_nettype wire

// ---- design/shwc_ctrl.sv ----
// Standby controller: wait select register, halt/stop entry, wake and reset hold.
// Assumes CLK is the always-running high-speed clock and CPU strobes are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module shwc_ctrl #(
   parameter int N_IRQ       = 8,
   parameter int WAIT_CYC_00 = shwc_pkg::WAIT_CYC_10,
   parameter int WAIT_CYC_01 = shwc_pkg::WAIT_CYC_12,
   parameter int WAIT_CYC_10 = shwc_pkg::WAIT_CYC_15,
   parameter int WAIT_CYC_11 = shwc_pkg::WAIT_CYC_17
) (
   // Clock and reset
   input  wire logic                     CLK,
   input  wire logic                     RST,
   // CPU memory port
   input  wire shwc_pkg::shwc_mem_req_t  MEM,
   output var  logic [7:0]               RDATA,
   // CPU standby strobes and interrupt flags
   input  wire logic                     HALT_EXEC,
   input  wire logic                     STOP_EXEC,
   input  wire logic [N_IRQ-1:0]         IRQ_REQUEST_FLAG,
   input  wire logic [N_IRQ-1:0]         IRQ_MASK_FLAG,
   input  wire logic                     IRQ_GLOBAL_ENABLE,
   // Clock generator
   input  wire shwc_pkg::shwc_clk_cfg_t  CLK_CFG,
   input  wire logic                     OSC_STARTED,
   input  wire logic                     LOW_SPEED_OSC_CLK,
   // Status and control outputs
   output var  logic                     CPU_CLK_EN,
   output var  logic                     HALT_ACTIVE,
   output var  logic                     STOP_ACTIVE,
   output var  logic                     PORT_HOLD,
   output var  logic                     OPT_HOLD,
   output var  logic                     WAKE_VECTOR,
   output var  logic                     WAKE_NEXT,
   output var  logic                     RESET_VECTOR_GO,
   output var  shwc_pkg::shwc_periph_run_t PERIPH_RUN
);
   localparam int CNT_W = shwc_pkg::CNT_W;

   initial begin
      if (N_IRQ < 1 || WAIT_CYC_00 < 1 || WAIT_CYC_01 < 1 || WAIT_CYC_10 < 1
          || WAIT_CYC_11 < 1 || WAIT_CYC_11 > (1 << CNT_W)) begin
         $error("shwc_ctrl: parameter out of range");
      end
   end

   shwc_pkg::shwc_state_t st_q;
   shwc_pkg::shwc_state_t st_d;
   logic [1:0]       wait_sel_q;
   logic [CNT_W-1:0] cnt_q;
   logic             opt_phase_q;
   logic             vec_q;
   logic             osc_s;
   logic             ls_s;
   logic             ls_prev_q;
   logic             ls_armed_q;
   logic             ls_rise;
   logic             wake;
   logic [CNT_W-1:0] stab_len;
   logic [CNT_W-1:0] resume_len;
   logic             ls_off;

   shwc_sync3 u_sync_osc (
      .CLK (CLK),
      .RST (RST),
      .d   (OSC_STARTED),
      .q   (osc_s)
   );

   shwc_sync3 u_sync_ls (
      .CLK (CLK),
      .RST (RST),
      .d   (LOW_SPEED_OSC_CLK),
      .q   (ls_s)
   );

   // Wake is any request with its mask clear, looked at every cycle
   assign wake    = |(IRQ_REQUEST_FLAG & ~IRQ_MASK_FLAG);
   assign ls_rise = ls_s & ~ls_prev_q & ls_armed_q;
   assign ls_off  = CLK_CFG.ls_stoppable & CLK_CFG.ls_stopped;

   // Wait length from the select code
   always_comb begin
      unique case (wait_sel_q)
         shwc_pkg::WAIT_CODE_10: stab_len = CNT_W'(WAIT_CYC_00 - 1);
         shwc_pkg::WAIT_CODE_12: stab_len = CNT_W'(WAIT_CYC_01 - 1);
         shwc_pkg::WAIT_CODE_15: stab_len = CNT_W'(WAIT_CYC_10 - 1);
         shwc_pkg::WAIT_CODE_17: stab_len = CNT_W'(WAIT_CYC_11 - 1);
      endcase
   end

   // Post-release delay follows the global enable at release time
   assign resume_len = IRQ_GLOBAL_ENABLE ? CNT_W'(shwc_pkg::VEC_WAIT_CLK - 1)
                                         : CNT_W'(shwc_pkg::NEXT_WAIT_CLK - 1);

   // Wait select register; reset to the longest wait so stop stays safe
   always_ff @(posedge CLK) begin
      if (RST) begin
         wait_sel_q <= shwc_pkg::WAIT_SEL_RST;
      end else if (MEM.we && MEM.addr == shwc_pkg::WAIT_SEL_ADDR) begin
         wait_sel_q <= MEM.wdata[shwc_pkg::WAIT_SEL_LSB +: 2];
      end
   end

   // Read data, upper bits always zero; unmapped reads give zero
   always_ff @(posedge CLK) begin
      if (RST) begin
         RDATA <= shwc_pkg::RDATA_IDLE;
      end else if (MEM.re && MEM.addr == shwc_pkg::WAIT_SEL_ADDR) begin
         RDATA <= {6'h00, wait_sel_q};
      end else begin
         RDATA <= shwc_pkg::RDATA_IDLE;
      end
   end

   // Next state
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         shwc_pkg::ST_OPT: begin
            if (opt_phase_q && cnt_q == '0) st_d = shwc_pkg::ST_RUN;
         end
         shwc_pkg::ST_RUN: begin
            // A pending wake turns entry straight into a release
            if (HALT_EXEC || STOP_EXEC) begin
               if (wake) st_d = shwc_pkg::ST_RESUME;
               else if (HALT_EXEC) st_d = shwc_pkg::ST_HALT;
               else st_d = shwc_pkg::ST_STOP;
            end
         end
         shwc_pkg::ST_HALT: begin
            if (wake) st_d = shwc_pkg::ST_RESUME;
         end
         shwc_pkg::ST_STOP: begin
            if (wake && CLK_CFG.src_xtal) st_d = shwc_pkg::ST_OSC;
            else if (wake) st_d = shwc_pkg::ST_RESUME;
         end
         shwc_pkg::ST_OSC: begin
            if (osc_s) st_d = shwc_pkg::ST_STAB;
         end
         shwc_pkg::ST_STAB: begin
            if (cnt_q == '0) st_d = shwc_pkg::ST_RESUME;
         end
         shwc_pkg::ST_RESUME: begin
            if (cnt_q == '0) st_d = shwc_pkg::ST_RUN;
         end
         default: st_d = shwc_pkg::ST_OPT;
      endcase
   end

   // State; reset from any state, halt included, restarts the option hold
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q <= shwc_pkg::ST_OPT;
      end else begin
         st_q <= st_d;
      end
   end

   // Shared down-counter for option hold, stabilization and resume delay
   always_ff @(posedge CLK) begin
      if (RST) begin
         cnt_q       <= CNT_W'(shwc_pkg::OPT_LS_PERIODS);
         opt_phase_q <= 1'b0;
         vec_q       <= 1'b0;
         ls_prev_q   <= 1'b0;
         ls_armed_q  <= 1'b0;
      end else begin
         ls_prev_q <= ls_s;
         // Count rises only after a real low, so a pin high at reset is no edge
         ls_armed_q <= ls_armed_q | (ls_prev_q & ~ls_s);
         if (st_q == shwc_pkg::ST_OPT && !opt_phase_q) begin
            if (ls_rise && cnt_q == CNT_W'(1)) begin
               opt_phase_q <= 1'b1;
               cnt_q       <= CNT_W'(shwc_pkg::OPT_HS_PERIODS - 1);
            end else if (ls_rise) begin
               cnt_q <= cnt_q - CNT_W'(1);
            end
         end else if (st_d == shwc_pkg::ST_RESUME && st_q != shwc_pkg::ST_RESUME) begin
            cnt_q <= resume_len;
            vec_q <= IRQ_GLOBAL_ENABLE;
         end else if (st_d == shwc_pkg::ST_STAB && st_q == shwc_pkg::ST_OSC) begin
            cnt_q <= stab_len;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
         end
      end
   end

   // Status outputs and one-cycle wake pulses
   always_ff @(posedge CLK) begin
      if (RST) begin
         CPU_CLK_EN      <= 1'b0;
         HALT_ACTIVE     <= 1'b0;
         STOP_ACTIVE     <= 1'b0;
         PORT_HOLD       <= 1'b0;
         OPT_HOLD        <= 1'b1;
         WAKE_VECTOR     <= 1'b0;
         WAKE_NEXT       <= 1'b0;
         RESET_VECTOR_GO <= 1'b0;
      end else begin
         CPU_CLK_EN      <= (st_d == shwc_pkg::ST_RUN);
         HALT_ACTIVE     <= (st_d == shwc_pkg::ST_HALT);
         STOP_ACTIVE     <= (st_d == shwc_pkg::ST_STOP) || (st_d == shwc_pkg::ST_OSC)
                            || (st_d == shwc_pkg::ST_STAB);
         PORT_HOLD       <= (st_d != shwc_pkg::ST_RUN) && (st_d != shwc_pkg::ST_OPT);
         OPT_HOLD        <= (st_d == shwc_pkg::ST_OPT);
         WAKE_VECTOR     <= (st_q == shwc_pkg::ST_RESUME) && cnt_q == '0 && vec_q;
         WAKE_NEXT       <= (st_q == shwc_pkg::ST_RESUME) && cnt_q == '0 && !vec_q;
         RESET_VECTOR_GO <= (st_q == shwc_pkg::ST_OPT) && (st_d == shwc_pkg::ST_RUN);
      end
   end

   // Peripheral run enables by mode; reset and option hold stop everything
   always_ff @(posedge CLK) begin
      if (RST) begin
         PERIPH_RUN <= '0;
      end else if (st_d == shwc_pkg::ST_RUN || st_d == shwc_pkg::ST_HALT
                   || st_d == shwc_pkg::ST_RESUME) begin
         PERIPH_RUN.tmr16  <= 1'b1;
         PERIPH_RUN.tmr8   <= 1'b1;
         PERIPH_RUN.adc    <= 1'b1;
         PERIPH_RUN.uart   <= 1'b1;
         PERIPH_RUN.lvd    <= 1'b1;
         PERIPH_RUN.extint <= 1'b1;
         PERIPH_RUN.tmh1   <= !(CLK_CFG.tmh1_on_ls && ls_off);
         // Watchdog on the peripheral clock counts only in run and during the release delay
         PERIPH_RUN.wdt    <= (st_d == shwc_pkg::ST_HALT)
                              ? (CLK_CFG.wdt_on_ls && !CLK_CFG.ls_stoppable)
                              : !(CLK_CFG.wdt_on_ls && ls_off);
      end else if (st_d == shwc_pkg::ST_OPT) begin
         PERIPH_RUN <= '0;
      end else begin
         PERIPH_RUN        <= '0;
         PERIPH_RUN.lvd    <= 1'b1;
         PERIPH_RUN.extint <= 1'b1;
         PERIPH_RUN.tmh1   <= CLK_CFG.tmh1_on_ls && !ls_off;
         PERIPH_RUN.wdt    <= CLK_CFG.wdt_on_ls && !CLK_CFG.ls_stoppable;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_halt_vec_release;
      st_q == shwc_pkg::ST_HALT && wake && IRQ_GLOBAL_ENABLE;
   endsequence
   sequence s_vec_wait;
      (!WAKE_VECTOR)[*8] ##1 WAKE_VECTOR;
   endsequence

   a_halt_gates_cpu: assert property (
      st_q == shwc_pkg::ST_RUN && HALT_EXEC && !wake |=> !CPU_CLK_EN && HALT_ACTIVE)
      else $error("halt did not gate the CPU clock");
   a_pending_no_halt: assert property (
      st_q == shwc_pkg::ST_RUN && (HALT_EXEC || STOP_EXEC) && wake
      |=> st_q == shwc_pkg::ST_RESUME && !HALT_ACTIVE)
      else $error("standby entered with a wake pending");
   a_vec_release_delay: assert property (
      s_halt_vec_release |=> !WAKE_VECTOR ##1 s_vec_wait)
      else $error("vectored wake not nine clocks after release");
   a_next_release_delay: assert property (
      st_q == shwc_pkg::ST_HALT && wake && !IRQ_GLOBAL_ENABLE |-> ##2 WAKE_NEXT && CPU_CLK_EN)
      else $error("resume wake not one clock after release");
   a_masked_holds_halt: assert property (
      st_q == shwc_pkg::ST_HALT && !wake |=> st_q == shwc_pkg::ST_HALT)
      else $error("halt left without an unmasked request");
   a_halt_port_hold: assert property (
      HALT_ACTIVE |-> PORT_HOLD && !CPU_CLK_EN)
      else $error("port latches not held in halt");
   a_halt_periph_run: assert property (
      HALT_ACTIVE |-> PERIPH_RUN.adc && PERIPH_RUN.uart && PERIPH_RUN.tmr16 && PERIPH_RUN.lvd)
      else $error("peripheral stopped during halt");
   a_halt_wdt: assert property (
      HALT_ACTIVE && $stable(CLK_CFG)
      |-> PERIPH_RUN.wdt == (CLK_CFG.wdt_on_ls && !CLK_CFG.ls_stoppable))
      else $error("watchdog run state wrong in halt");
   a_stop_no_wait: assert property (
      st_q == shwc_pkg::ST_STOP && wake && !CLK_CFG.src_xtal |=> st_q == shwc_pkg::ST_RESUME)
      else $error("wait inserted for on-chip clock");
   a_stab_length: assert property (
      st_q == shwc_pkg::ST_OSC && osc_s |=> st_q == shwc_pkg::ST_STAB && cnt_q == $past(stab_len))
      else $error("stabilization count not loaded from select code");
   a_opt_hs_hold: assert property (
      st_q == shwc_pkg::ST_OPT && !opt_phase_q ##1 opt_phase_q
      |-> cnt_q == CNT_W'(shwc_pkg::OPT_HS_PERIODS - 1) && OPT_HOLD)
      else $error("option hold high-speed phase wrong length");
   a_reg_upper_zero: assert property (
      MEM.re && MEM.addr == shwc_pkg::WAIT_SEL_ADDR |=> RDATA[7:2] == 6'h00)
      else $error("wait select upper bits not zero");
endmodule // shwc_ctrl
`default_nettype wire

// ---- bench/shwc_irq_model.sv ----
// Partner model: request, mask and global enable flags as the CPU side holds them.
// Assumes the bench issues set and clear commands between clock edges.
`timescale 1ns/10ps
`default_nettype none
module shwc_irq_model #(
   parameter int N_IRQ = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Bench commands
   input  wire logic [N_IRQ-1:0] set_req,
   input  wire logic             clr_req,
   input  wire logic [N_IRQ-1:0] mask_in,
   input  wire logic             ie_in,
   // Design side
   input  wire logic             wake_vector,
   output var  logic [N_IRQ-1:0] req_flag,
   output var  logic [N_IRQ-1:0] mask_flag,
   output var  logic             global_enable
);
   logic [N_IRQ-1:0] pend;
   logic [N_IRQ-1:0] first;

   // Masks and enable pass straight through, so a mask change is seen the same cycle
   assign mask_flag     = mask_in;
   assign global_enable = ie_in;
   assign pend          = req_flag & ~mask_flag;
   assign first         = pend & (~pend + 1'b1);

   // Acceptance clears only the lowest pending unmasked source, as a CPU would
   always_ff @(posedge clk) begin
      if (rst || clr_req) begin
         req_flag <= '0;
      end else if (wake_vector) begin
         req_flag <= (req_flag & ~first) | set_req;
      end else begin
         req_flag <= req_flag | set_req;
      end
   end
endmodule // shwc_irq_model
`default_nettype wire

// ---- bench/test_standby_halt_wake_control.sv ----
// Self-checking bench for the standby, halt and wake controller.
// Assumes a 20 MHz CLK and shortened stabilization counts set by parameter.
`timescale 1ns/10ps
`default_nettype none
module test_standby_halt_wake_control;
   localparam int WCYC [4] = '{16, 32, 64, 128};
   logic                       CLK, RST, halt_exec, stop_exec, osc_started, ls_clk, clr_req;
   logic                       ie_in, ie, cpu_clk_en, halt_act, stop_act, port_hold, opt_hold;
   logic                       wvec, wnext, rvgo;
   logic [7:0]                 rdata, set_req, mask_in, req_flag, mask_flag, rd, wd;
   logic [1:0]                 code;
   logic [2:0]                 k;
   shwc_pkg::shwc_mem_req_t    mem;
   shwc_pkg::shwc_clk_cfg_t    cfg;
   shwc_pkg::shwc_periph_run_t prun;
   int                         err_count, checks, seed, n, i;

   // Clocks: low-speed one free running and unrelated in phase
   initial CLK = 1'b0;
   always #25 CLK = ~CLK;
   initial ls_clk = 1'b0;
   always #365 ls_clk = ~ls_clk;

   shwc_ctrl #(.N_IRQ(8), .WAIT_CYC_00(16), .WAIT_CYC_01(32), .WAIT_CYC_10(64),
      .WAIT_CYC_11(128)) dut (
      .CLK(CLK), .RST(RST), .MEM(mem), .RDATA(rdata), .HALT_EXEC(halt_exec),
      .STOP_EXEC(stop_exec), .IRQ_REQUEST_FLAG(req_flag), .IRQ_MASK_FLAG(mask_flag),
      .IRQ_GLOBAL_ENABLE(ie), .CLK_CFG(cfg), .OSC_STARTED(osc_started),
      .LOW_SPEED_OSC_CLK(ls_clk), .CPU_CLK_EN(cpu_clk_en), .HALT_ACTIVE(halt_act),
      .STOP_ACTIVE(stop_act), .PORT_HOLD(port_hold), .OPT_HOLD(opt_hold),
      .WAKE_VECTOR(wvec), .WAKE_NEXT(wnext), .RESET_VECTOR_GO(rvgo), .PERIPH_RUN(prun));

   shwc_irq_model cpu (
      .clk(CLK), .rst(RST), .set_req(set_req), .clr_req(clr_req), .mask_in(mask_in),
      .ie_in(ie_in), .wake_vector(wvec), .req_flag(req_flag), .mask_flag(mask_flag),
      .global_enable(ie));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic step(input int c);
      repeat (c) @(negedge CLK);
   endtask

   // Bounded wait for a pulse: 0 reset go, 1 vectored wake, 2 next wake
   task automatic wait_go(input int sel, input int lim, output int cnt);
      logic hit;
      cnt = 0;
      hit = 1'b0;
      while (!hit && cnt < lim) begin
         @(posedge CLK);
         #1;
         cnt++;
         case (sel)
            0: hit = (rvgo === 1'b1);
            1: hit = (wvec === 1'b1);
            default: hit = (wnext === 1'b1);
         endcase
      end
      if (!hit) check("pulse arrived", 0, 1);
      @(negedge CLK);
   endtask

   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      mem = '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      step(1);
      mem.we = 1'b0;
   endtask

   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
      mem.addr = a;
      mem.re = 1'b1;
      step(1);
      mem.re = 1'b0;
      d = rdata;
      step(1);
      check("rdata idle", rdata, 8'h00);
   endtask

   task automatic enter(input logic halt);
      halt_exec = halt;
      stop_exec = !halt;
      step(1);
      halt_exec = 1'b0;
      stop_exec = 1'b0;
   endtask

   task automatic clear_irq;
      mask_in = 8'hff;
      clr_req = 1'b1;
      step(1);
      clr_req = 1'b0;
   endtask

   task automatic do_reset;
      RST = 1'b1;
      step(4);
      check("opt hold", opt_hold, 1);
      check("cpu clk in reset", cpu_clk_en, 0);
      check("halt cleared", halt_act, 0);
      RST = 1'b0;
      wait_go(0, 400, n);
      check("hold long enough", n >= 96 + 100, 1);
      check("hold not too long", n <= 96 + 140, 1);
      check("cpu clk at go", cpu_clk_en, 1);
   endtask

   // Peripherals in halt: only timer one and watchdog depend on the low-speed clock
   function automatic shwc_pkg::shwc_periph_run_t exp_run(input shwc_pkg::shwc_clk_cfg_t c);
      shwc_pkg::shwc_periph_run_t r;
      r = '1;
      r.tmh1 = !(c.tmh1_on_ls && c.ls_stoppable && c.ls_stopped);
      r.wdt = c.wdt_on_ls && !c.ls_stoppable;
      return r;
   endfunction

   // Watchdog: the whole run needs under two thousand cycles
   initial begin
      #(20000 * 50);
      err_count++;
      complete_run;
   end

   // Main sequence, inputs moved at the falling edge
   initial begin
      seed = 32'h0b57ce0c;
      {halt_exec, stop_exec, osc_started, clr_req, ie_in} = '0;
      {set_req, mask_in, err_count, checks} = {16'h00ff, 64'h0};
      mem = '0;
      cfg = '0;
      RST = 1'b1;
      step(1);
      do_reset;
      $display("test reset hold done");
      // Random codes with junk in the upper bits, then an unmapped address
      for (i = 0; i < 6; i++) begin
         code = 2'($random(seed));
         wd = 8'($random(seed));
         reg_wr(shwc_pkg::WAIT_SEL_ADDR, {wd[7:2], code});
         reg_rd(shwc_pkg::WAIT_SEL_ADDR, rd);
         check("wait select", rd, {6'h00, code});
      end
      reg_wr(16'hfff5, 8'h02);
      reg_rd(16'hfff5, rd);
      check("unmapped read", rd, 8'h00);
      reg_rd(shwc_pkg::WAIT_SEL_ADDR, rd);
      check("unmapped write dropped", rd, {6'h00, code});
      $display("test register done");
      // Halt, masked request ignored, then release with enable set and clear
      for (i = 0; i < 2; i++) begin
         k = 3'($random(seed));
         ie_in = (i == 0);
         set_req = 8'h01 << k;
         step(1);
         set_req = 8'h00;
         enter(1'b1);
         check("cpu clk gated", cpu_clk_en, 0);
         check("halt entered", halt_act, 1);
         check("ports held", port_hold, 1);
         step(20);
         check("masked stays", halt_act, 1);
         mask_in[k] = 1'b0;
         wait_go((i == 0) ? 1 : 2, 40, n);
         check("wake delay", n, (i == 0) ? 10 : 2);
         check("cpu clk back", cpu_clk_en, 1);
         check("ports free", port_hold, 0);
         clear_irq;
      end
      // Pending unmasked request at entry ends halt at once
      set_req = 8'h01;
      step(1);
      set_req = 8'h00;
      mask_in = 8'hfe;
      ie_in = 1'b0;
      enter(1'b1);
      wait_go(2, 40, n);
      check("immediate release", n <= 2, 1);
      clear_irq;
      $display("test halt release done");
      // Peripheral enables over every low-speed clock setting, then reset out of halt
      enter(1'b1);
      for (i = 0; i < 16; i++) begin
         cfg = '{src_xtal: 1'b0, ls_stoppable: i[3], ls_stopped: i[2], tmh1_on_ls: i[1],
                 wdt_on_ls: i[0]};
         step(3);
         check("periph run", prun, exp_run(cfg));
      end
      do_reset;
      $display("test halt peripherals and reset done");
      // Stop with a crystal: no counting before oscillation, then the chosen length
      for (i = 0; i < 4; i++) begin
         // Oscillator is at rest again before stop, so the synchroniser sees it low
         osc_started = 1'b0;
         reg_wr(shwc_pkg::WAIT_SEL_ADDR, {6'h00, 2'(i)});
         cfg = '0;
         cfg.src_xtal = 1'b1;
         set_req = 8'h80;
         step(1);
         set_req = 8'h00;
         enter(1'b0);
         check("stop entered", stop_act, 1);
         mask_in[7] = 1'b0;
         step(200);
         check("no count before osc", stop_act, 1);
         osc_started = 1'b1;
         wait_go(2, 400, n);
         check("wait at least", n >= WCYC[i], 1);
         check("wait at most", n <= WCYC[i] + 10, 1);
         clear_irq;
      end
      // Stop on a non-crystal source resumes without a wait
      cfg = '0;
      osc_started = 1'b0;
      set_req = 8'h10;
      step(1);
      set_req = 8'h00;
      enter(1'b0);
      mask_in[4] = 1'b0;
      wait_go(2, 40, n);
      check("no wait", n <= 6, 1);
      clear_irq;
      $display("test stop release done");
      complete_run;
   end
endmodule // test_standby_halt_wake_control
`default_nettype wire
